// ==== ctrl_ops_pkg.sv ====
// Purpose: shared constants and types for the control-instruction executor
// Assumes: one clock, synchronous active-low reset, decode stage on the same clock
// Notes: opcode bit patterns are decoded upstream into op_kind_t
//
// What this block does
// - disable op clears flag; acceptance blocked one cycle later
// - enable op sets flag; acceptance effective one cycle later
// - watchdog-stop-arm op sets stop permission only
// - watchdog stops only on stop action after arming
// - power-down ops act only right after arming op
package ctrl_ops_pkg;

    // ****************************************
    // instruction kinds delivered by decode
    // ****************************************
    typedef enum logic [2:0] {
        other_op,
        interrupt_disable_op,
        interrupt_enable_op,
        watchdog_stop_arm_op,
        powerdown_arm_op,
        powerdown_op_a,
        powerdown_op_b
    } op_kind_t;

    // ****************************************
    // timing and reset values
    // ****************************************
    localparam int IRQ_EFFECT_DELAY_MC = 1;
    localparam logic IRQ_ENABLE_RST = 1'h0;
    localparam logic IRQ_ACCEPT_RST = 1'h0;
    localparam logic WDT_ARM_RST = 1'h0;
    localparam logic WDT_RUN_RST = 1'h1;
    localparam logic PD_ARM_RST = 1'h0;
    localparam logic PD_PULSE_RST = 1'h0;

endpackage

// ==== mc_delay.sv ====
// Purpose: carries a level to its output after a count of machine cycles
// Assumes: mc_tick is a one-clock pulse at the end of each machine cycle
// Notes: a new load restarts the count and replaces the held value
`timescale 1ns/1ps
module mc_delay #(
    parameter int DELAY_MC = 1,
    parameter logic RST_VAL = 1'h0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic din,
    input wire logic mc_tick,
    output logic dout
);
    localparam int CW = (DELAY_MC < 2) ? 1 : $clog2(DELAY_MC + 1);
    localparam logic [CW-1:0] LOAD_VAL = CW'(DELAY_MC);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic held_reg;
    logic held_next;
    logic dout_reg;
    logic dout_next;
    wire counting = (cnt_reg != '0);
    wire expire = counting && mc_tick && (cnt_reg == CW'(1));

    // load beats a coincident tick: the waiting cycle starts after execution
    assign cnt_next = load ? LOAD_VAL : ((counting && mc_tick) ? cnt_reg - CW'(1) : cnt_reg);
    assign held_next = load ? din : held_reg;
    assign dout_next = (expire && !load) ? held_reg : dout_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            held_reg <= RST_VAL;
            dout_reg <= RST_VAL;
        end else begin
            cnt_reg <= cnt_next;
            held_reg <= held_next;
            dout_reg <= dout_next;
        end
    end

    assign dout = dout_reg;
endmodule

// ==== intr_wdt_powerdown_ctrl_ops.sv ====
// Purpose: executes interrupt enable/disable, watchdog stop arming and power-down arming
// Assumes: instr_exec pulses once per executed instruction, with op_kind valid in that clock
// Notes: mc_tick marks the end of each machine cycle; all inputs on clk
`timescale 1ns/1ps
module intr_wdt_powerdown_ctrl_ops #(
    parameter int IRQ_DELAY_MC = ctrl_ops_pkg::IRQ_EFFECT_DELAY_MC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_exec,
    input wire ctrl_ops_pkg::op_kind_t op_kind,
    input wire logic mc_tick,
    input wire logic wdt_stop_action,
    output logic irq_enable_flag,
    output logic irq_accept_en,
    output logic wdt_stop_armed,
    output logic wdt_running,
    output logic pd_armed,
    output logic pd_enter_a,
    output logic pd_enter_b,
    output logic pd_refused
);

    // ****************************************
    // helper functions
    // ****************************************
    // one executed instruction of the wanted kind in this clock
    function automatic logic op_hit(
        input logic exec,
        input ctrl_ops_pkg::op_kind_t kind,
        input ctrl_ops_pkg::op_kind_t want
    );
        return exec && (kind == want);
    endfunction

    // set wins over clear when both fall in one clock
    function automatic logic set_clr_hold(
        input logic set,
        input logic clr,
        input logic cur
    );
        return set ? 1'h1 : (clr ? 1'h0 : cur);
    endfunction

    // ****************************************
    // decode of the executed instruction
    // ****************************************
    wire exec_irq_dis = op_hit(instr_exec, op_kind, ctrl_ops_pkg::interrupt_disable_op);
    wire exec_irq_en = op_hit(instr_exec, op_kind, ctrl_ops_pkg::interrupt_enable_op);
    wire exec_wdt_arm = op_hit(instr_exec, op_kind, ctrl_ops_pkg::watchdog_stop_arm_op);
    wire exec_pd_arm = op_hit(instr_exec, op_kind, ctrl_ops_pkg::powerdown_arm_op);
    wire exec_pd_a = op_hit(instr_exec, op_kind, ctrl_ops_pkg::powerdown_op_a);
    wire exec_pd_b = op_hit(instr_exec, op_kind, ctrl_ops_pkg::powerdown_op_b);
    wire exec_pd_any = exec_pd_a || exec_pd_b;
    wire exec_irq_any = exec_irq_dis || exec_irq_en;
    // any other executed instruction ends the power-down arming
    wire exec_pd_drop = instr_exec && !exec_pd_arm;

    // ****************************************
    // interrupt enable flag
    // ****************************************
    logic irq_flag_reg;
    logic irq_flag_next;
    logic irq_accept_w;

    // flag itself changes at once; only acceptance waits
    assign irq_flag_next = set_clr_hold(exec_irq_en, exec_irq_dis, irq_flag_reg);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_flag_reg <= ctrl_ops_pkg::IRQ_ENABLE_RST;
        end else begin
            irq_flag_reg <= irq_flag_next;
        end
    end

    // acceptance follows the flag one machine cycle after the executing one
    // a new op during the wait restarts it, so the last op decides
    mc_delay #(
        .DELAY_MC(IRQ_DELAY_MC),
        .RST_VAL(ctrl_ops_pkg::IRQ_ACCEPT_RST)
    ) u_irq_delay (
        .clk(clk),
        .rst_b(rst_b),
        .load(exec_irq_any),
        .din(irq_flag_next),
        .mc_tick(mc_tick),
        .dout(irq_accept_w)
    );

    // ****************************************
    // watchdog stop permission
    // ****************************************
    typedef enum logic [1:0] {
        WDT_FREE,
        WDT_ARMED,
        WDT_HALTED
    } wdt_state_t;

    wdt_state_t wdt_state_reg;
    wdt_state_t wdt_state_next;
    logic wdt_arm_reg;
    logic wdt_arm_next;
    logic wdt_run_reg;
    logic wdt_run_next;

    // arming alone never halts; a stop action in the arming clock is not prior
    always_comb begin
        wdt_state_next = wdt_state_reg;
        case (wdt_state_reg)
            WDT_FREE: begin
                if (exec_wdt_arm) begin
                    wdt_state_next = WDT_ARMED;
                end
            end
            WDT_ARMED: begin
                if (wdt_stop_action) begin
                    wdt_state_next = WDT_HALTED;
                end
            end
            WDT_HALTED: begin
                wdt_state_next = WDT_HALTED;
            end
            default: begin
                wdt_state_next = WDT_FREE;
            end
        endcase
    end

    // halted is final until reset: no op restarts the timer
    assign wdt_arm_next = (wdt_state_next != WDT_FREE);
    assign wdt_run_next = (wdt_state_next != WDT_HALTED);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdt_state_reg <= WDT_FREE;
        end else begin
            wdt_state_reg <= wdt_state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdt_arm_reg <= ctrl_ops_pkg::WDT_ARM_RST;
        end else begin
            wdt_arm_reg <= wdt_arm_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdt_run_reg <= ctrl_ops_pkg::WDT_RUN_RST;
        end else begin
            wdt_run_reg <= wdt_run_next;
        end
    end

    // ****************************************
    // power-down arming
    // ****************************************
    logic pd_arm_reg;
    logic pd_arm_next;
    logic pd_a_reg;
    logic pd_a_next;
    logic pd_b_reg;
    logic pd_b_next;
    logic pd_ref_reg;
    logic pd_ref_next;
    wire pd_ok = pd_arm_reg && exec_pd_any;

    // arming lasts until the next executed instruction that is not another power-down arming op
    assign pd_arm_next = set_clr_hold(exec_pd_arm, exec_pd_drop, pd_arm_reg);
    assign pd_a_next = pd_ok && exec_pd_a;
    assign pd_b_next = pd_ok && exec_pd_b;
    // an unarmed power-down op only reports itself, it never sleeps
    assign pd_ref_next = exec_pd_any && !pd_arm_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pd_arm_reg <= ctrl_ops_pkg::PD_ARM_RST;
        end else begin
            pd_arm_reg <= pd_arm_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pd_a_reg <= ctrl_ops_pkg::PD_PULSE_RST;
        end else begin
            pd_a_reg <= pd_a_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pd_b_reg <= ctrl_ops_pkg::PD_PULSE_RST;
        end else begin
            pd_b_reg <= pd_b_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pd_ref_reg <= ctrl_ops_pkg::PD_PULSE_RST;
        end else begin
            pd_ref_reg <= pd_ref_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign irq_enable_flag = irq_flag_reg;
    assign irq_accept_en = irq_accept_w;
    assign wdt_stop_armed = wdt_arm_reg;
    assign wdt_running = wdt_run_reg;
    assign pd_armed = pd_arm_reg;
    assign pd_enter_a = pd_a_reg;
    assign pd_enter_b = pd_b_reg;
    assign pd_refused = pd_ref_reg;

endmodule

// ==== ctrl_ops_monitor.sv ====
// Purpose: port checker for the control-op executor
// Assumes: bound to the top module
// Notes: acceptance may only follow the flag, one clock after a tick
`timescale 1ns/1ps
module ctrl_ops_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_exec,
    input wire ctrl_ops_pkg::op_kind_t op_kind,
    input wire logic mc_tick,
    input wire logic wdt_stop_action,
    input wire logic irq_enable_flag,
    input wire logic irq_accept_en,
    input wire logic wdt_stop_armed,
    input wire logic wdt_running,
    input wire logic pd_armed,
    input wire logic pd_enter_a,
    input wire logic pd_enter_b,
    input wire logic pd_refused
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic irq_op = instr_exec &&
        (op_kind inside {ctrl_ops_pkg::interrupt_disable_op, ctrl_ops_pkg::interrupt_enable_op});
    wire logic pd_op = instr_exec &&
        (op_kind inside {ctrl_ops_pkg::powerdown_op_a, ctrl_ops_pkg::powerdown_op_b});
    AST_FLAG: assert property (
        irq_op |=> irq_enable_flag == ($past(op_kind) == ctrl_ops_pkg::interrupt_enable_op))
        else $error("enable flag wrong after op");
    AST_ACCEPT: assert property (
        $changed(irq_accept_en) |-> $past(mc_tick) && irq_accept_en == $past(irq_enable_flag))
        else $error("acceptance moved out of turn");
    AST_ARM: assert property (
        instr_exec && op_kind == ctrl_ops_pkg::watchdog_stop_arm_op |=> wdt_stop_armed)
        else $error("stop permission not set");
    AST_STOP: assert property ($fell(wdt_running) |-> $past(wdt_stop_armed && wdt_stop_action))
        else $error("watchdog stopped unarmed");
    AST_PD_GO: assert property (pd_enter_a || pd_enter_b |-> $past(pd_armed && pd_op))
        else $error("power-down entered unarmed");
    AST_PD_NO: assert property (pd_op && !pd_armed |=> pd_refused && !pd_enter_a && !pd_enter_b)
        else $error("unarmed power-down not refused");
    AST_PD_ARM: assert property (
        instr_exec |=> pd_armed == ($past(op_kind) == ctrl_ops_pkg::powerdown_arm_op))
        else $error("power-down arming wrong after op");
endmodule

// ==== decode_model.sv ====
// Purpose: decode-stage stand-in issuing executed ops and ticks
// Assumes: req and req_kind change after clk edges
// Notes: a machine cycle is four clocks here
`timescale 1ns/1ps
module decode_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req,
    input wire ctrl_ops_pkg::op_kind_t req_kind,
    output logic instr_exec,
    output ctrl_ops_pkg::op_kind_t op_kind,
    output logic mc_tick
);
    logic [1:0] phase_reg;
    assign mc_tick = (phase_reg == 2'h3);
    always_ff @(posedge clk) begin
        phase_reg <= rst_b ? phase_reg + 2'h1 : 2'h0;
        instr_exec <= rst_b & req;
        op_kind <= req ? req_kind : ctrl_ops_pkg::other_op;
    end
endmodule

// ==== intr_wdt_powerdown_ctrl_ops_bench.sv ====
// Purpose: directed checks of the control-op executor
// Assumes: ops reach the block through decode_model
// Notes: each scenario judges its own results
`timescale 1ns/1ps
module intr_wdt_powerdown_ctrl_ops_bench;
    logic clk = 1'h0, rst_b = 1'h0, req = 1'h0, wdt_stop_action = 1'h0;
    ctrl_ops_pkg::op_kind_t req_kind = ctrl_ops_pkg::other_op, op_kind;
    logic instr_exec, mc_tick, irq_enable_flag, irq_accept_en, wdt_stop_armed, wdt_running;
    logic pd_armed, pd_enter_a, pd_enter_b, pd_refused;
    int n_fail = 0, samples_checked = 0;
    decode_model dec (.clk, .rst_b, .req, .req_kind, .instr_exec, .op_kind, .mc_tick);
    intr_wdt_powerdown_ctrl_ops dut (.clk, .rst_b, .instr_exec, .op_kind, .mc_tick, .wdt_stop_action,
        .irq_enable_flag, .irq_accept_en, .wdt_stop_armed, .wdt_running, .pd_armed, .pd_enter_a, .pd_enter_b, .pd_refused);
    initial forever #25 clk = ~clk;
    task automatic chk(input string what, input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic op(input ctrl_ops_pkg::op_kind_t k);
        @(posedge clk);
        req <= 1'h1;
        req_kind <= k;
    endtask
    // last op is taken at the edge just before return
    task automatic settle();
        @(posedge clk);
        req <= 1'h0;
        @(posedge clk);
        #1;
    endtask
    // a machine cycle is four clocks, so acceptance must come within four edges
    task automatic wait_accept(input logic exp);
        for (int i = 0; i < 4 && irq_accept_en !== exp; i++) begin
            @(posedge clk);
            #1;
        end
        chk("accept", irq_accept_en, exp);
        if (irq_accept_en !== exp) close_out();
    endtask
    task automatic pulse_stop();
        @(posedge clk) wdt_stop_action <= 1'h1;
        @(posedge clk) wdt_stop_action <= 1'h0;
        #1;
    endtask
    task automatic irq_scen();
        op(ctrl_ops_pkg::interrupt_enable_op);
        settle();
        chk("flag", irq_enable_flag, 1'h1);
        chk("accept early", irq_accept_en, 1'h0);
        wait_accept(1'h1);
        op(ctrl_ops_pkg::interrupt_disable_op);
        settle();
        chk("flag", irq_enable_flag, 1'h0);
        chk("accept held", irq_accept_en, 1'h1);
        wait_accept(1'h0);
    endtask
    task automatic wdt_scen();
        pulse_stop();
        chk("run unarmed", wdt_running, 1'h1);
        op(ctrl_ops_pkg::watchdog_stop_arm_op);
        settle();
        chk("armed", wdt_stop_armed, 1'h1);
        chk("run armed", wdt_running, 1'h1);
        pulse_stop();
        chk("run stopped", wdt_running, 1'h0);
    endtask
    task automatic pd_scen();
        op(ctrl_ops_pkg::powerdown_op_a);
        settle();
        chk("refused", pd_refused, 1'h1);
        chk("enter a unarmed", pd_enter_a, 1'h0);
        op(ctrl_ops_pkg::powerdown_arm_op);
        settle();
        chk("pd armed", pd_armed, 1'h1);
        op(ctrl_ops_pkg::powerdown_op_a);
        settle();
        chk("enter a", pd_enter_a, 1'h1);
        chk("pd armed after a", pd_armed, 1'h0);
        op(ctrl_ops_pkg::powerdown_arm_op);
        op(ctrl_ops_pkg::powerdown_op_b);
        settle();
        chk("enter b", pd_enter_b, 1'h1);
        op(ctrl_ops_pkg::powerdown_arm_op);
        op(ctrl_ops_pkg::other_op);
        op(ctrl_ops_pkg::powerdown_op_a);
        settle();
        chk("enter a late", pd_enter_a, 1'h0);
        chk("refused late", pd_refused, 1'h1);
    endtask
    // mid-run reset must bring a halted watchdog back; the flag is already clear before it and must stay clear
    task automatic reset_scen();
        @(posedge clk);
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        #1;
        chk("run after reset", wdt_running, ctrl_ops_pkg::WDT_RUN_RST);
        chk("armed after reset", wdt_stop_armed, ctrl_ops_pkg::WDT_ARM_RST);
        chk("flag after reset", irq_enable_flag, ctrl_ops_pkg::IRQ_ENABLE_RST);
        op(ctrl_ops_pkg::interrupt_enable_op);
        settle();
        chk("flag first op", irq_enable_flag, 1'h1);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        irq_scen();
        wdt_scen();
        pd_scen();
        reset_scen();
        close_out();
    end
endmodule
bind intr_wdt_powerdown_ctrl_ops ctrl_ops_monitor mon (.clk, .rst_b, .instr_exec, .op_kind, .mc_tick, .wdt_stop_action,
    .irq_enable_flag, .irq_accept_en, .wdt_stop_armed, .wdt_running, .pd_armed, .pd_enter_a, .pd_enter_b, .pd_refused);
